//--- bfs_top.sv
// Breaker failure scheme with Avalon-MM settings slave.
// Assumes current magnitudes arrive on mclk in 0.001 pu steps; pins are async.
//
// Notes on behaviour
// - Start comes from the protection trip input
// - With latch check on, latch releases once current drops below supervision
// - Start check requires current above supervision
// - Latch check holds only above supervision
// - Re-trip asserts at once on start
// - Enabled path timeout declares failure, zone trip
// - Each path individually enabled
// - Early path: timer, aux closed, fault current
// - Main path: timer and fault current only
// - Early or main timer timeout enables high-set, then low-set
// - Slow path: timer, aux closed, in service
// - Status, re-trip and held zone trip outputs
// - Failure raises event and trip indicator, plus phase A indicator in single-pole mode
// - Pole mode; neutral supervision three-pole only
// - Phase supervision level gates start and latch
// - Inhibit input stops the scheme
// - Path delays in 1 ms steps, 16 bits
// - Zone trip held for the dropout setting
// - High-to-low detector delay is its setting
//
// Our own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
`include "bfs_cfg.svh"

module bfs_top #(
  parameter int TICK_CYCLES = `BFS_MS_NS / `BFS_CLK_PERIOD_NS
) (
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire bfs_pkg::bfs_avs_req_t avs,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  input  wire bfs_pkg::bfs_pins_t   pins,
  input  wire logic [`BFS_SW-1:0]   phase_mag,
  input  wire logic [`BFS_SW-1:0]   neutral_mag,
  output logic                      retrip_out,
  output logic                      zone_trip_out,
  output logic                      failed_event,
  output logic                      trip_led,
  output logic                      phase_a_led,
  output bfs_pkg::bfs_stat_t        status
);
  import bfs_pkg::*;

  localparam int PW = $clog2(TICK_CYCLES);
  localparam logic [PW-1:0] PRESC_LAST = PW'(TICK_CYCLES - 1);

  // Level comparison shared by every current detector
  function automatic logic above(input logic [`BFS_SW-1:0] mag,
                                 input logic [`BFS_SW-1:0] lvl);
    above = (mag > lvl);
  endfunction

  // ---------------- Register bus ----------------
  bfs_ctrl_t          ctrl_r;
  logic [`BFS_SW-1:0] set_r [`BFS_NSET];
  logic               wait_r;
  logic [31:0]        rdata_r;
  logic [31:0]        rdata_nxt;
  logic [3:0]         set_idx;
  logic               set_hit;
  logic               ctrl_hit;
  logic               stat_hit;
  logic               wr_take;
  logic               req;

  assign req      = avs.read || avs.write;
  // Access completes on the second cycle of any request
  assign wr_take  = avs.write && !wait_r;
  assign ctrl_hit = (avs.address == `BFS_IDX_CTRL);
  assign stat_hit = (avs.address == `BFS_IDX_STATUS);
  assign set_idx  = avs.address - `BFS_IDX_SET0;
  assign set_hit  = (avs.address >= `BFS_IDX_SET0) && (set_idx < 4'(`BFS_NSET));

  always_ff @(posedge mclk) begin
    if (reset) begin
      wait_r  <= 1'b1;
      rdata_r <= '0;
    end else begin
      wait_r  <= !(req && wait_r);
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_r <= `BFS_CTRL_RST;
    end else if (wr_take && ctrl_hit && avs.byteenable[0]) begin
      ctrl_r <= avs.writedata[`BFS_CW-1:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `BFS_NSET; gi++) begin : g_set
      localparam logic [`BFS_SW-1:0] RST =
        (gi >= `BFS_SET_PH_SUPV) ? `BFS_LVL_RST : `BFS_DLY_RST;
      wire hit = wr_take && set_hit && (set_idx == 4'(gi));
      always_ff @(posedge mclk) begin
        if (reset) begin
          set_r[gi] <= RST;
        end else if (hit) begin
          if (avs.byteenable[0]) set_r[gi][7:0]  <= avs.writedata[7:0];
          if (avs.byteenable[1]) set_r[gi][15:8] <= avs.writedata[15:8];
        end
      end
    end
  endgenerate

  // ---------------- Input conditioning ----------------
  bfs_pins_t pins_s;

  bfs_sync #(.W($bits(bfs_pins_t))) u_sync (
    .mclk  (mclk),
    .reset (reset),
    .d     (pins),
    .q     (pins_s)
  );

  logic [PW-1:0] presc_r;
  logic          tick_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      presc_r <= '0;
      tick_r  <= 1'b0;
    end else begin
      presc_r <= (presc_r == PRESC_LAST) ? '0 : presc_r + 1'b1;
      tick_r  <= (presc_r == PRESC_LAST);
    end
  end

  // ---------------- Initiation ----------------
  wire three_pole = !ctrl_r.failure_pole_mode;
  wire clear_w    = !ctrl_r.func_en || pins_s.scheme_inhibit_in;

  wire ph_supv_w = above(phase_mag, set_r[`BFS_SET_PH_SUPV]);
  wire n_supv_w  = three_pole && above(neutral_mag, set_r[`BFS_SET_N_SUPV]);
  wire supv_w    = ph_supv_w || n_supv_w;

  logic latch_r;
  wire  start_ok   = pins_s.three_pole_start_in &&
                     (!ctrl_r.start_current_check_en || supv_w);
  wire  hold_ok    = !ctrl_r.latch_current_check_en || supv_w;
  wire  latch_nxt  = !clear_w && (start_ok || (latch_r && hold_ok));
  wire  initiated  = !clear_w && (start_ok || latch_r);

  logic retrip_r;
  always_ff @(posedge mclk) begin
    if (reset) begin
      latch_r  <= 1'b0;
      retrip_r <= 1'b0;
    end else begin
      latch_r  <= latch_nxt;
      retrip_r <= initiated;
    end
  end

  // ---------------- Delayed paths ----------------
  logic [2:0] path_en;
  logic [2:0] path_exp;
  assign path_en = {ctrl_r.slow_path_en, ctrl_r.main_path_en, ctrl_r.early_path_en};

  generate
    for (gi = 0; gi < 3; gi++) begin : g_path
      bfs_ms_timer #(.DW(`BFS_SW)) u_tmr (
        .mclk    (mclk),
        .reset   (reset),
        .run     (initiated && path_en[gi]),
        .ms_tick (tick_r),
        .delay   (set_r[`BFS_SET_EARLY + gi]),
        .expired (path_exp[gi])
      );
    end
  endgenerate

  // Expiry counts only while its path is still enabled
  logic [2:0] path_on;
  assign path_on = path_exp & path_en;

  // High-set first, low-set after its own delay from early or main timeout
  logic lo_exp;
  wire  hi_run = path_on[0] || path_on[1];
  bfs_ms_timer #(.DW(`BFS_SW)) u_loset (
    .mclk    (mclk),
    .reset   (reset),
    .run     (hi_run),
    .ms_tick (tick_r),
    .delay   (set_r[`BFS_SET_LOSET_DLY]),
    .expired (lo_exp)
  );

  wire hi_en  = hi_run && !lo_exp;
  wire hi_det = above(phase_mag, set_r[`BFS_SET_PH_HI]) ||
                (three_pole && above(neutral_mag, set_r[`BFS_SET_N_HI]));
  wire lo_det = above(phase_mag, set_r[`BFS_SET_PH_LO]) ||
                (three_pole && above(neutral_mag, set_r[`BFS_SET_N_LO]));
  wire fault_cur = (hi_en && hi_det) || (lo_exp && lo_det);

  // Early aux is the pole A contact in single-pole mode
  wire aux_closed = pins_s.early_aux_contact_in;
  wire early_w = path_on[0] && aux_closed && fault_cur;
  wire main_w  = path_on[1] && fault_cur;
  wire slow_w  = path_on[2] && aux_closed && !pins_s.out_of_service_in;
  wire fail_w  = !clear_w && (early_w || main_w || slow_w);

  // ---------------- Outputs ----------------
  logic [2:0] op_r;
  logic       fail_r;
  logic       zone_r;
  logic       event_r;
  logic       led_r;
  logic       pha_led_r;
  logic       hi_r;
  logic       lo_r;
  logic       drop_exp;

  // Dropout runs only after the failure condition goes away
  bfs_ms_timer #(.DW(`BFS_SW)) u_hold (
    .mclk    (mclk),
    .reset   (reset),
    .run     (zone_r && !fail_w),
    .ms_tick (tick_r),
    .delay   (set_r[`BFS_SET_HOLD]),
    .expired (drop_exp)
  );

  wire zone_nxt = !clear_w && (fail_w || (zone_r && !drop_exp));

  always_ff @(posedge mclk) begin
    if (reset) begin
      op_r      <= '0;
      fail_r    <= 1'b0;
      zone_r    <= 1'b0;
      event_r   <= 1'b0;
      led_r     <= 1'b0;
      pha_led_r <= 1'b0;
      hi_r      <= 1'b0;
      lo_r      <= 1'b0;
    end else begin
      op_r      <= clear_w ? 3'h0 : {slow_w, main_w, early_w};
      fail_r    <= fail_w;
      zone_r    <= zone_nxt;
      event_r   <= fail_w && !fail_r;
      // Indicators stay lit until the function is switched off
      led_r     <= ctrl_r.func_en && (led_r || fail_w);
      pha_led_r <= ctrl_r.func_en && (pha_led_r || (fail_w && ctrl_r.failure_pole_mode));
      hi_r      <= !clear_w && hi_en;
      lo_r      <= !clear_w && lo_exp;
    end
  end

  bfs_stat_t stat_w;
  assign stat_w = '{trip_led: led_r, loset_active: lo_r, hiset_active: hi_r,
                    slow_op: op_r[2], main_op: op_r[1], early_op: op_r[0],
                    zone_trip: zone_r, retrip: retrip_r, start_latched: latch_r};

  always_comb begin
    rdata_nxt = '0;
    if (avs.read && wait_r) begin
      if (ctrl_hit) rdata_nxt[`BFS_CW-1:0] = ctrl_r;
      else if (stat_hit) rdata_nxt[$bits(bfs_stat_t)-1:0] = stat_w;
      else if (set_hit) rdata_nxt[`BFS_SW-1:0] = set_r[set_idx];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      status <= '0;
    end else begin
      status <= stat_w;
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign retrip_out      = retrip_r;
  assign zone_trip_out   = zone_r;
  assign failed_event    = event_r;
  assign trip_led        = led_r;
  assign phase_a_led     = pha_led_r;

  // ---------------- Assertions ----------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_fail_rise;
    fail_w && !fail_r;
  endsequence

  sequence s_zone_then_event;
    zone_r && event_r;
  endsequence

  retrip_on_start_a: assert property (start_ok && !clear_w |=> retrip_r)
    else $error("Re-trip missing after start");
  start_check_a: assert property (
    ctrl_r.start_current_check_en && !supv_w && !latch_r |=> !retrip_r && !latch_r)
    else $error("Start accepted below supervision");
  latch_release_a: assert property (
    latch_r && ctrl_r.latch_current_check_en && !supv_w && !start_ok |=> !latch_r)
    else $error("Latch held below supervision");
  disabled_clear_a: assert property (!ctrl_r.func_en |=> !retrip_r && !zone_r && !latch_r)
    else $error("Outputs not cleared when disabled");
  inhibit_stop_a: assert property (pins_s.scheme_inhibit_in |=> !retrip_r && op_r == 3'h0)
    else $error("Inhibit did not stop scheme");
  path_enable_a: assert property (op_r[0] |-> $past(ctrl_r.early_path_en))
    else $error("Disabled early path operated");
  early_cond_a: assert property (op_r[0] |-> $past(path_exp[0] && aux_closed && fault_cur))
    else $error("Early path operated without conditions");
  main_cond_a: assert property (op_r[1] |-> $past(path_exp[1] && fault_cur))
    else $error("Main path operated without current");
  slow_cond_a: assert property (
    op_r[2] |-> $past(aux_closed && !pins_s.out_of_service_in && path_exp[2]))
    else $error("Slow path operated out of service");
  loset_swap_a: assert property (lo_r |-> !hi_r && $past(hi_run, 2))
    else $error("Low-set enabled without prior high-set");
  neutral_mode_a: assert property (
    ctrl_r.failure_pole_mode && ctrl_r.start_current_check_en && !ph_supv_w && !latch_r
    |=> !retrip_r)
    else $error("Neutral current started single-pole scheme");
  zone_trip_a: assert property (s_fail_rise |=> s_zone_then_event ##1 !event_r)
    else $error("Failure did not raise zone trip and event");
  main_enable_a: assert property (op_r[1] |-> $past(ctrl_r.main_path_en))
    else $error("Disabled main path operated");
  slow_enable_a: assert property (op_r[2] |-> $past(ctrl_r.slow_path_en))
    else $error("Disabled slow path operated");
  hiset_start_a: assert property ($rose(hi_run) && !clear_w |=> hi_r)
    else $error("High-set not enabled on path timeout");

  // Zone trip may only fall by dropout expiry, clear or reset
  zone_drop_a: assert property ($fell(zone_r) |-> $past(drop_exp || clear_w || reset))
    else $error("Zone trip dropped before hold expired");
  event_led_a: assert property (event_r |-> zone_r && led_r)
    else $error("Failure event without zone trip or indicator");
  phase_led_a: assert property (event_r && $past(ctrl_r.failure_pole_mode) |-> pha_led_r)
    else $error("Phase indicator missing in single-pole mode");
  led_sticky_a: assert property (led_r && ctrl_r.func_en |=> led_r)
    else $error("Trip indicator dropped while enabled");
endmodule

//--- bfs_cfg.svh
// Constants for the breaker failure scheme: register map, reset values, timing.
// Assumes inclusion by bfs_pkg, bfs_top and the testbench.
`ifndef BFS_CFG_SVH
`define BFS_CFG_SVH

// Time base
`define BFS_CLK_PERIOD_NS 4
`define BFS_MS_NS         1000000

// Register word indices (byte address is four times the index)
`define BFS_AW            4
`define BFS_IDX_CTRL      4'h0
`define BFS_IDX_STATUS    4'h1
`define BFS_IDX_SET0      4'h2
`define BFS_NSET          11

// Order of settings words after BFS_IDX_SET0
`define BFS_SET_EARLY     0
`define BFS_SET_MAIN      1
`define BFS_SET_SLOW      2
`define BFS_SET_HOLD      3
`define BFS_SET_LOSET_DLY 4
`define BFS_SET_PH_SUPV   5
`define BFS_SET_N_SUPV    6
`define BFS_SET_PH_HI     7
`define BFS_SET_N_HI      8
`define BFS_SET_PH_LO     9
`define BFS_SET_N_LO      10

// Widths and reset values
`define BFS_SW            16
`define BFS_CW            7
`define BFS_CTRL_RST      7'h7C
`define BFS_DLY_RST       16'h0000
`define BFS_LVL_RST       16'h041A

`endif

//--- bfs_pkg.sv
// Types shared by the breaker failure scheme modules.
// Assumes bfs_cfg.svh is on the include path.
`include "bfs_cfg.svh"

package bfs_pkg;

  // Bit 0 is func_en, bit 6 is slow_path_en
  typedef struct packed {
    logic slow_path_en;
    logic main_path_en;
    logic early_path_en;
    logic latch_current_check_en;
    logic start_current_check_en;
    logic failure_pole_mode;
    logic func_en;
  } bfs_ctrl_t;

  typedef struct packed {
    logic                  read;
    logic                  write;
    logic [`BFS_AW-1:0]    address;
    logic [31:0]           writedata;
    logic [3:0]            byteenable;
  } bfs_avs_req_t;

  typedef struct packed {
    logic scheme_inhibit_in;
    logic out_of_service_in;
    logic early_aux_contact_in;
    logic three_pole_start_in;
  } bfs_pins_t;

  typedef struct packed {
    logic trip_led;
    logic loset_active;
    logic hiset_active;
    logic slow_op;
    logic main_op;
    logic early_op;
    logic zone_trip;
    logic retrip;
    logic start_latched;
  } bfs_stat_t;

endpackage

//--- bfs_sync.sv
// Two-stage synchroniser for a group of pin levels.
// Assumes inputs are asynchronous levels, not pulses.
`timescale 1ns/10ps

module bfs_sync #(
  parameter int W = 4
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

//--- bfs_ms_timer.sv
// Millisecond pickup timer: expires once run has held for delay ticks.
// Assumes ms_tick is a one-cycle pulse once per millisecond.
`timescale 1ns/10ps

module bfs_ms_timer #(
  parameter int DW = 16
) (
  input  wire logic          mclk,
  input  wire logic          reset,
  input  wire logic          run,
  input  wire logic          ms_tick,
  input  wire logic [DW-1:0] delay,
  output logic               expired
);
  logic [DW-1:0] cnt_r;
  logic [DW-1:0] cnt_nxt;
  wire           done = (cnt_r >= delay);

  // Count saturates at the delay so it never wraps
  assign cnt_nxt = !run ? '0 : (ms_tick && !done) ? cnt_r + 1'b1 : cnt_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_r   <= '0;
      expired <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      expired <= run && done;
    end
  end
endmodule

//--- bfs_brk_model.sv
// Breaker model: trip coil, early auxiliary contact and current through the breaker.
// Assumes the bench sets its mode lines just after a rising edge of mclk.
`timescale 1ns/10ps

module bfs_brk_model #(
  parameter int OPEN_CYC = 5
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        rearm,
  input  wire logic        mech_ok,
  input  wire logic        intr_ok,
  input  wire logic [15:0] lvl,
  input  wire logic [15:0] nlvl,
  input  wire logic        trip_cmd,
  input  wire logic        zone_trip,
  output logic             aux_closed,
  output logic [15:0]      phase_mag,
  output logic [15:0]      neutral_mag
);
  logic       closed_r;
  logic       cleared_r;
  logic [7:0] cnt_r;
  logic       flowing;

  // Remote breakers end the fault once the zone is tripped
  assign flowing     = !cleared_r && (closed_r || !intr_ok);
  assign aux_closed  = closed_r;
  assign phase_mag   = flowing ? lvl : 16'h0000;
  assign neutral_mag = flowing ? nlvl : 16'h0000;

  always_ff @(posedge mclk) begin
    if (reset || rearm) begin
      closed_r  <= 1'b1;
      cleared_r <= 1'b0;
      cnt_r     <= 8'h00;
    end else begin
      // A stuck mechanism never counts, so the contact stays closed
      if (trip_cmd && closed_r && mech_ok) begin
        cnt_r <= cnt_r + 8'h01;
      end
      if (cnt_r == 8'(OPEN_CYC)) begin
        closed_r <= 1'b0;
      end
      if (zone_trip) begin
        cleared_r <= 1'b1;
      end
    end
  end
endmodule

//--- tb_breaker_failure_scheme.sv
// Self-checking bench for the breaker failure scheme, one case per table row.
// Assumes bfs_pkg, bfs_top and bfs_brk_model are compiled first.
`timescale 1ns/10ps
`include "bfs_cfg.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module tb_breaker_failure_scheme;
  import bfs_pkg::*;
  // Short tick keeps millisecond timers within a brief run
  localparam int TCK  = 10;
  localparam int HOLD = 4;
  typedef struct packed {
    logic [6:0]  ctrl;
    logic [15:0] mag;
    logic [15:0] nmag;
    logic        mech, intr, oos, inh, rt, trip;
    logic [3:0]  lo, hi;
    logic        hchk, rtend;
  } bfs_case_t;
  logic         mclk, reset, start, oos, inh, mech, intr, rearm, aux;
  logic         waitreq, retrip, zone, fail_ev, led, led_a;
  logic [15:0]  lvl, nlvl, phase_mag, neutral_mag;
  logic [31:0]  rdata, q;
  bfs_avs_req_t avs;
  bfs_pins_t    pins;
  bfs_stat_t    status;
  bfs_case_t    cases [16];
  bfs_case_t    c;
  logic [3:0]   sa [7];
  logic [15:0]  sv [7];
  int           bad_count, checked, i, k, m, h;

  assign pins = '{scheme_inhibit_in: inh, out_of_service_in: oos,
                  early_aux_contact_in: aux, three_pole_start_in: start};

  bfs_top #(.TICK_CYCLES(TCK)) dut (
    .mclk(mclk), .reset(reset), .avs(avs), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .pins(pins), .phase_mag(phase_mag),
    .neutral_mag(neutral_mag), .retrip_out(retrip), .zone_trip_out(zone),
    .failed_event(fail_ev), .trip_led(led), .phase_a_led(led_a), .status(status));

  bfs_brk_model brk (
    .mclk(mclk), .reset(reset), .rearm(rearm), .mech_ok(mech), .intr_ok(intr),
    .lvl(lvl), .nlvl(nlvl), .trip_cmd(retrip), .zone_trip(zone),
    .aux_closed(aux), .phase_mag(phase_mag), .neutral_mag(neutral_mag));

  task summarize();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Request stands until the edge that samples waitrequest low; read data taken there
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    avs <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hF};
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (waitreq === 1'b0) begin
        q = rdata;
        break;
      end
    end
    avs <= '0;
    // One idle edge so the next call never reassigns the request in this step
    @(posedge mclk);
    if (n == 40) begin
      bad_count++;
      summarize();
    end
  endtask

  task automatic chk_rd(input logic [3:0] a, input logic [31:0] e);
    av(1'b0, a, 32'h0000_0000);
    `CHK("readback", e, q)
  endtask

  task automatic run(input int ci);
    c = cases[ci];
    av(1'b1, `BFS_IDX_CTRL, 32'h0000_0000);
    rearm <= 1'b1;
    repeat (3) @(posedge mclk);
    `CHK("cleared", 4'h0, {retrip, zone, led, led_a})
    rearm <= 1'b0;
    {mech, intr, oos, inh} <= {c.mech, c.intr, c.oos, c.inh};
    {lvl, nlvl} <= {c.mag, c.nmag};
    av(1'b1, `BFS_IDX_CTRL, {25'h0, c.ctrl});
    repeat (8) @(posedge mclk);
    start <= 1'b1;
    for (k = 1; k < 9; k++) begin
      @(negedge mclk);
      if (retrip === 1'b1) break;
    end
    `CHK("retrip", c.rt, retrip === 1'b1 && k <= 5)
    @(posedge mclk);
    start <= 1'b0;
    for (m = 0; m < 200; m++) begin
      @(negedge mclk);
      if (fail_ev === 1'b1) break;
    end
    `CHK("failure", c.trip, m < 200)
    if (c.trip && m < 200) begin
      `CHK("fail_time", 1'b1, m >= c.lo * TCK && m <= c.hi * TCK + 8)
      `CHK("trip_outs", {2'b11, c.ctrl[1]}, {zone, led, led_a})
      @(negedge mclk);
      `CHK("event_pulse", 1'b0, fail_ev)
      `CHK("status", 4'hF, {status.zone_trip, status.trip_led, status.retrip, |status[5:3]})
      for (h = 0; c.hchk && h < 200; h++) begin
        @(negedge mclk);
        if (zone !== 1'b1) break;
      end
      if (c.hchk) `CHK("zone_hold", 1'b1, h >= (HOLD-1) * TCK && h <= HOLD * TCK + 12)
    end
    @(negedge mclk);
    `CHK("retrip_end", c.rtend, retrip)
    @(posedge mclk);
    $display("case %0d done", ci);
  endtask

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial begin
    reset = 1'b1;
    avs = '0;
    {start, oos, inh, mech, intr, rearm} = 6'h00;
    {lvl, nlvl} = 32'h0000_0000;
    bad_count = 0;
    checked = 0;
    // ctrl mag nmag mech intr oos inh rt trip lo hi hchk rtend
    cases = '{'{7'h21,16'h1000,16'h0,1,0,0,0,1,1,2,3,1,1},
              '{7'h01,16'h1000,16'h0,1,0,0,0,1,0,0,0,0,1},
              '{7'h11,16'h1000,16'h0,0,0,0,0,1,1,1,2,1,1},
              '{7'h11,16'h1000,16'h0,1,0,0,0,1,0,0,0,0,1},
              '{7'h41,16'h0000,16'h0,0,0,0,0,1,1,4,5,0,1},
              '{7'h41,16'h0000,16'h0,0,0,1,0,1,0,0,0,0,1},
              '{7'h25,16'h0200,16'h0,1,0,0,0,0,0,0,0,0,0},
              '{7'h25,16'h1000,16'h0,1,0,0,0,1,1,2,3,1,1},
              '{7'h21,16'h0200,16'h0,1,0,0,0,1,1,4,6,1,1},
              '{7'h21,16'h1000,16'h0,1,0,0,1,0,0,0,0,0,0},
              '{7'h23,16'h1000,16'h0,1,0,0,0,1,1,2,3,1,1},
              '{7'h20,16'h1000,16'h0,1,0,0,0,0,0,0,0,0,0},
              '{7'h29,16'h1000,16'h0,1,1,0,0,1,0,0,0,0,0},
              '{7'h29,16'h1000,16'h0,1,0,0,0,1,1,2,3,1,0},
              '{7'h25,16'h0200,16'h1000,1,0,0,0,1,1,2,3,1,1},
              '{7'h27,16'h0200,16'h1000,1,0,0,0,0,0,0,0,0,0}};
    // Early 2, main 3, slow 5, hold 4, low-set 3 ms; phase high and low levels
    sa = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'hB};
    sv = '{16'h0002, 16'h0003, 16'h0005, 16'h0004, 16'h0003, 16'h0800, 16'h0100};
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    chk_rd(`BFS_IDX_CTRL, 32'(`BFS_CTRL_RST));
    chk_rd(4'h2, 32'h0000_0000);
    chk_rd(4'h7, 32'h0000_041A);
    av(1'b1, 4'h3, 32'hFFFF_0003);
    chk_rd(4'h3, 32'h0000_0003);
    av(1'b1, `BFS_IDX_STATUS, 32'h0000_01FF);
    chk_rd(`BFS_IDX_STATUS, 32'h0000_0000);
    chk_rd(4'hD, 32'h0000_0000);
    for (k = 0; k < 7; k++) begin
      av(1'b1, sa[k], {16'h0000, sv[k]});
    end
    $display("registers done");
    for (i = 0; i < 16; i++) begin
      run(i);
    end
    summarize();
  end
endmodule
